// ---- cii_core_irq.sv ----
// Purpose: interrupt controller of a small 8-bit core: flags, enables, vectoring,
//          context shadows, wake from sleep
// Assumes: each pclk edge is one clock phase, four phases per instruction cycle;
//          the core follows the flush/push/load/pop/restore pulses
// Notes:   registers on a zero-wait APB slave; shadows at ADDR_SHADOW and up
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps

// Notes on behaviour
// - reset leaves all interrupt enables cleared
// - redirect needs global plus own enable
// - flags set on event regardless of enables
// - taken interrupt flushes the prefetched instruction
// - entry clears global enable, pushes PC
// - entry loads PC with vector 0004h
// - events during service only set flags
// - return pops, restores context, sets global enable
// - pending flag serviced once global enable returns
// - synchronous sources reach vector in 3-4 cycles
// - asynchronous sources reach vector in 3-5 cycles
// - latency independent of instruction length
// - pin flag sampled once per cycle, phase one
// - enabled clockless-capable source wakes; vector only if global
// - instruction after sleep executes before vectoring
// - pin edge selectable rising or falling
// - selected pin edge sets flag, may redirect
// - entry copies context into shadows, except timeout/powerdown
// - return restores context from (writable) shadows
// - shadows readable and writable by software
// - only clockless-capable sources may wake
module cii_core_irq
	import cii_pkg::*;
(
	input  wire logic                  pclk,            // clock, 100 MHz
	input  wire logic                  presetn,         // async reset, low
	input  wire logic                  psel,            // apb select
	input  wire logic                  penable,         // apb access phase
	input  wire logic                  pwrite,          // apb write
	input  wire logic [cii_pkg::ADDR_W-1:0] paddr,      // apb byte address
	input  wire logic [cii_pkg::DATA_W-1:0] pwdata,     // apb write data
	output logic      [cii_pkg::DATA_W-1:0] prdata,     // apb read data
	output logic                       pready,          // apb ready
	output logic                       pslverr,         // apb error, unmapped
	input  wire logic                  ext_pin,         // external interrupt pin
	input  wire logic                  timer_ovf_event, // core timer overflow pulse
	input  wire logic                  ioc_pending,     // pin-change flags, level
	input  wire logic [7:0]            periph_event_a,  // peripheral event pulses a
	input  wire logic [7:0]            periph_event_b,  // peripheral event pulses b
	input  wire logic [7:0]            periph_event_c,  // peripheral event pulses c
	input  wire logic                  core_sleeping,   // core is in sleep
	input  wire logic                  irq_ret_exec,    // return-from-irq executes
	input  wire logic [cii_pkg::PC_W-1:0] core_pc,      // current program counter
	input  wire cii_pkg::cii_ctx_t     ctx_live,        // core context to save
	output logic                       phase_first,     // marks first phase
	output logic                       flush_prefetch,  // discard prefetched instr
	output logic                       push_pc,         // push push_value
	output logic      [cii_pkg::PC_W-1:0] push_value,   // return address
	output logic                       load_pc,         // load load_value into PC
	output logic      [cii_pkg::PC_W-1:0] load_value,   // vector address
	output logic                       pop_pc,          // pop return address
	output logic                       ctx_restore_valid, // restore context now
	output cii_pkg::cii_ctx_t          ctx_restore,     // context from shadows
	output logic                       wake_req,        // wake the core
	output logic                       irq_request      // gated request level
);
	// flag update: a hardware set always beats a software clear
	function automatic logic [7:0] flag_next(input logic [7:0] cur, input logic [7:0] hw_set,
	                                         input logic wr, input logic [7:0] wdata,
	                                         input logic [7:0] impl);
		flag_next = (hw_set | (wr ? wdata : cur)) & impl;
	endfunction

	// any source both flagged and enabled
	function automatic logic any_armed(input logic [7:0] flags, input logic [7:0] enables);
		any_armed = |(flags & enables);
	endfunction

	logic [1:0]  q_phase;
	cii_state_t  state;
	logic [7:0]  ctrl;
	logic        edge_sel;
	logic [7:0]  pie_a;
	logic [7:0]  pie_b;
	logic [7:0]  pie_c;
	logic [7:0]  pir_a;
	logic [7:0]  pir_b;
	logic [7:0]  pir_c;
	logic [7:0]  shadow [SHADOW_COUNT];
	logic        req_sampled;
	logic        sleep_prev;
	logic [1:0]  wake_hold;
	logic        ext_event;
	logic        cycle_start;
	logic        wr_en;
	logic        rd_setup;
	logic        hit_ctrl;
	logic        hit_option;
	logic        hit_pie_a;
	logic        hit_pie_b;
	logic        hit_pie_c;
	logic        hit_pir_a;
	logic        hit_pir_b;
	logic        hit_pir_c;
	logic        hit_shadow;
	logic        hit_any;
	logic [2:0]  shadow_idx;
	logic [7:0]  wbyte;
	logic [7:0]  rd_byte;
	logic [7:0]  ctrl_flags;
	logic [7:0]  ctrl_enables;
	logic        core_armed;
	logic        periph_armed;
	logic        take_irq;
	logic        enter_vector;
	logic [7:0]  next_ctrl;
	logic [7:0]  ctrl_hw_set;
	logic        wake_armed;
	logic        woke;

	cii_edge_if eif ();

	// pin edge detection lives in its own small module
	assign eif.pin_level       = ext_pin;
	assign eif.edge_rising_sel = edge_sel;
	assign ext_event           = eif.edge_event;

	cii_edge_detect u_edge (
		.pclk    (pclk),
		.presetn (presetn),
		.eif     (eif.detector)
	);

	// apb decode; slave is zero-wait so pready stays high
	assign wr_en      = psel & penable & pwrite;
	assign rd_setup   = psel & ~penable & ~pwrite;
	assign hit_ctrl   = (paddr == ADDR_CTRL);
	assign hit_option = (paddr == ADDR_OPTION);
	assign hit_pie_a  = (paddr == ADDR_PIE_A);
	assign hit_pie_b  = (paddr == ADDR_PIE_B);
	assign hit_pie_c  = (paddr == ADDR_PIE_C);
	assign hit_pir_a  = (paddr == ADDR_PIR_A);
	assign hit_pir_b  = (paddr == ADDR_PIR_B);
	assign hit_pir_c  = (paddr == ADDR_PIR_C);
	assign hit_shadow = (paddr >= ADDR_SHADOW) && (paddr <= ADDR_SHADOW_END) && (paddr[1:0] == 2'h0);
	assign hit_any    = hit_ctrl | hit_option | hit_pie_a | hit_pie_b | hit_pie_c
	                  | hit_pir_a | hit_pir_b | hit_pir_c | hit_shadow;
	assign shadow_idx = 3'((paddr - ADDR_SHADOW) >> 2);
	assign wbyte      = pwdata[7:0];
	assign pready     = 1'h1;
	assign pslverr    = psel & penable & ~hit_any;

	// read mux, if/else chain over the map
	always_comb
	begin
		if (hit_ctrl)
			rd_byte = ctrl;
		else if (hit_option)
			rd_byte = 8'(edge_sel) << BIT_EDGE_SEL;
		else if (hit_pie_a)
			rd_byte = pie_a;
		else if (hit_pie_b)
			rd_byte = pie_b;
		else if (hit_pie_c)
			rd_byte = pie_c;
		else if (hit_pir_a)
			rd_byte = pir_a;
		else if (hit_pir_b)
			rd_byte = pir_b;
		else if (hit_pir_c)
			rd_byte = pir_c;
		else if (hit_shadow)
			rd_byte = shadow[shadow_idx];
		else
			rd_byte = BYTE_RESET;
	end

	// read data captured in setup so it is a flop in the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= '0;
		else if (rd_setup)
			prdata <= {24'h000000, rd_byte};
	end

	// instruction cycle phase counter, one pclk per phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q_phase <= PHASE_FIRST;
		else if (q_phase == PHASE_FOURTH)
			q_phase <= PHASE_FIRST;
		else
			q_phase <= q_phase + 2'h1;
	end

	assign cycle_start = (q_phase == PHASE_FIRST);
	assign phase_first = cycle_start;

	// request gating: core terms plus peripheral group term
	assign ctrl_flags   = {5'h00, ctrl[BIT_TMR_IF], ctrl[BIT_EXT_IF], ioc_pending};
	assign ctrl_enables = {5'h00, ctrl[BIT_TMR_IE], ctrl[BIT_EXT_IE], ctrl[BIT_IOC_IE]};
	assign core_armed   = any_armed(ctrl_flags, ctrl_enables);
	assign periph_armed = ctrl[BIT_GROUP_EN] & (any_armed(pir_a, pie_a) | any_armed(pir_b, pie_b)
	                    | any_armed(pir_c, pie_c));
	assign irq_request  = ctrl[BIT_GLOBAL_EN] & (core_armed | periph_armed);

	// wake needs only the enables, and only from clockless-capable sources
	assign wake_armed = any_armed(pir_a & WAKE_CAP_A, pie_a) | any_armed(pir_b & WAKE_CAP_B, pie_b)
	                  | any_armed(pir_c & WAKE_CAP_C, pie_c)
	                  | (WAKE_CAP_EXT & ctrl[BIT_EXT_IF] & ctrl[BIT_EXT_IE])
	                  | (WAKE_CAP_IOC & ioc_pending & ctrl[BIT_IOC_IE])
	                  | (WAKE_CAP_TMR & ctrl[BIT_TMR_IF] & ctrl[BIT_TMR_IE]);
	assign wake_req   = core_sleeping & wake_armed;
	assign woke       = sleep_prev & ~core_sleeping;

	// a request seen at one phase-one boundary starts entry at the next boundary;
	// entry is paced by instruction cycles only, never by instruction length
	// the wake edge itself is blocked too, since the hold count loads only after it
	assign take_irq     = cycle_start & (state == ST_RUN) & req_sampled & ctrl[BIT_GLOBAL_EN]
	                    & ~core_sleeping & ~woke & (wake_hold == 2'h0);
	assign enter_vector = cycle_start & (state == ST_VECTOR);

	// control register: hardware-set flags win over software clears
	assign ctrl_hw_set = (8'(timer_ovf_event) << BIT_TMR_IF) | (8'(ext_event) << BIT_EXT_IF);

	always_comb
	begin
		next_ctrl = flag_next(ctrl, ctrl_hw_set, wr_en & hit_ctrl, wbyte, CTRL_RESET | 8'hfe);
		next_ctrl[BIT_IOC_IF] = 1'h0; // ioc flag mirrors ioc_pending, read-only
		if (enter_vector)
			next_ctrl[BIT_GLOBAL_EN] = 1'h0;
		else if (irq_ret_exec)
			next_ctrl[BIT_GLOBAL_EN] = 1'h1;
	end

	// the stored ioc bit reloads the pending level on every clock, so it reads back one clock behind
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl <= CTRL_RESET;
		else
			ctrl <= next_ctrl | (8'(ioc_pending) << BIT_IOC_IF);
	end

	// option edge select and peripheral enables
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			edge_sel <= EDGE_SEL_RESET;
			pie_a    <= BYTE_RESET;
			pie_b    <= BYTE_RESET;
			pie_c    <= BYTE_RESET;
		end
		else if (wr_en)
		begin
			if (hit_option)
				edge_sel <= wbyte[BIT_EDGE_SEL];
			if (hit_pie_a)
				pie_a <= wbyte & PERIPH_IMPL_A;
			if (hit_pie_b)
				pie_b <= wbyte & PERIPH_IMPL_B;
			if (hit_pie_c)
				pie_c <= wbyte & PERIPH_IMPL_C;
		end
	end

	// peripheral flags set on every event, whatever the enables
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pir_a <= BYTE_RESET;
			pir_b <= BYTE_RESET;
			pir_c <= BYTE_RESET;
		end
		else
		begin
			pir_a <= flag_next(pir_a, periph_event_a, wr_en & hit_pir_a, wbyte, PERIPH_IMPL_A);
			pir_b <= flag_next(pir_b, periph_event_b, wr_en & hit_pir_b, wbyte, PERIPH_IMPL_B);
			pir_c <= flag_next(pir_c, periph_event_c, wr_en & hit_pir_c, wbyte, PERIPH_IMPL_C);
		end
	end

	// request sampled once per instruction cycle, at phase one
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			req_sampled <= 1'h0;
		else if (cycle_start)
			req_sampled <= irq_request;
	end

	// after a wake, one full instruction must run before any vectoring
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sleep_prev <= 1'h0;
			wake_hold  <= 2'h0;
		end
		else
		begin
			sleep_prev <= core_sleeping;
			if (woke)
				wake_hold <= WAKE_HOLD_CYCLES;
			else if (cycle_start && wake_hold != 2'h0)
				wake_hold <= wake_hold - 2'h1;
		end
	end

	// entry sequence: flush cycle, then vector cycle, then run at the vector
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= ST_RUN;
		else if (cycle_start)
		begin
			case (state)
				ST_RUN:
					if (take_irq)
						state <= ST_FLUSH;
				ST_FLUSH:
					state <= ST_VECTOR;
				ST_VECTOR:
					state <= ST_RUN;
				default:
					state <= ST_RUN;
			endcase
		end
	end

	// core-facing one-cycle command pulses
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flush_prefetch    <= 1'h0;
			push_pc           <= 1'h0;
			push_value        <= '0;
			load_pc           <= 1'h0;
			load_value        <= '0;
			pop_pc            <= 1'h0;
			ctx_restore_valid <= 1'h0;
		end
		else
		begin
			flush_prefetch    <= take_irq;
			push_pc           <= enter_vector;
			load_pc           <= enter_vector;
			pop_pc            <= irq_ret_exec;
			ctx_restore_valid <= irq_ret_exec;
			if (enter_vector)
			begin
				push_value <= core_pc;
				load_value <= IRQ_VECTOR;
			end
		end
	end

	// shadows: hardware save on entry beats a software write in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < SHADOW_COUNT; i++)
				shadow[i] <= BYTE_RESET;
		end
		else if (enter_vector)
		begin
			for (int i = 0; i < SHADOW_COUNT; i++)
				shadow[i] <= ctx_live[i];
			shadow[SH_STATUS] <= ctx_live[SH_STATUS] & ~STATUS_TOPD_MASK;
		end
		else if (wr_en && hit_shadow)
			shadow[shadow_idx] <= wbyte;
	end

	// restore image straight from the shadow flops
	always_comb
	begin
		for (int i = 0; i < SHADOW_COUNT; i++)
			ctx_restore[i] = shadow[i];
	end
endmodule

// ---- cii_pkg.sv ----
// Purpose: shared constants and types of the core interrupt unit
// Assumes: one pclk edge is one clock phase; four phases make one instruction cycle
// Notes:   register offsets are byte addresses on the APB slave
package cii_pkg;

	// apb geometry
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	localparam int          PC_W          = 15;

	// register byte offsets
	localparam logic [7:0]  ADDR_CTRL     = 8'h00;
	localparam logic [7:0]  ADDR_OPTION   = 8'h04;
	localparam logic [7:0]  ADDR_PIE_A    = 8'h08;
	localparam logic [7:0]  ADDR_PIE_B    = 8'h0c;
	localparam logic [7:0]  ADDR_PIE_C    = 8'h10;
	localparam logic [7:0]  ADDR_PIR_A    = 8'h14;
	localparam logic [7:0]  ADDR_PIR_B    = 8'h18;
	localparam logic [7:0]  ADDR_PIR_C    = 8'h1c;
	localparam logic [7:0]  ADDR_SHADOW   = 8'h20;
	localparam logic [7:0]  ADDR_SHADOW_END = 8'h3c;

	// control register bit positions, and the option edge select bit
	localparam int          BIT_GLOBAL_EN = 7;
	localparam int          BIT_GROUP_EN  = 6;
	localparam int          BIT_TMR_IE    = 5;
	localparam int          BIT_EXT_IE    = 4;
	localparam int          BIT_IOC_IE    = 3;
	localparam int          BIT_TMR_IF    = 2;
	localparam int          BIT_EXT_IF    = 1;
	localparam int          BIT_IOC_IF    = 0;
	localparam int          BIT_EDGE_SEL  = 6;

	// reset values
	localparam logic [7:0]  CTRL_RESET    = 8'h00;
	localparam logic        EDGE_SEL_RESET = 1'h1;
	localparam logic [7:0]  BYTE_RESET    = 8'h00;

	// implemented bits of the peripheral enable/flag registers
	localparam logic [7:0]  PERIPH_IMPL_A = 8'hff;
	localparam logic [7:0]  PERIPH_IMPL_B = 8'hef;
	localparam logic [7:0]  PERIPH_IMPL_C = 8'hff;

	// sources that keep running with the system clock stopped
	localparam logic [7:0]  WAKE_CAP_A    = 8'h00;
	localparam logic [7:0]  WAKE_CAP_B    = 8'h80;
	localparam logic [7:0]  WAKE_CAP_C    = 8'h00;
	localparam logic        WAKE_CAP_EXT  = 1'h1;
	localparam logic        WAKE_CAP_IOC  = 1'h1;
	localparam logic        WAKE_CAP_TMR  = 1'h0;

	// fixed vector, phase numbering and wake hold
	localparam logic [14:0] IRQ_VECTOR    = 15'h0004;
	localparam logic [1:0]  PHASE_FIRST   = 2'h0;
	localparam logic [1:0]  PHASE_FOURTH  = 2'h3;
	localparam logic [1:0]  WAKE_HOLD_CYCLES = 2'h2;

	// shadow slots, in address order from ADDR_SHADOW
	localparam int          SHADOW_COUNT  = 8;
	localparam int          SH_W          = 0;
	localparam int          SH_STATUS     = 1;
	localparam int          SH_BANK       = 2;
	localparam int          SH_PC_HIGH    = 3;
	localparam int          SH_FSR0L      = 4;
	localparam int          SH_FSR0H      = 5;
	localparam int          SH_FSR1L      = 6;
	localparam int          SH_FSR1H      = 7;
	localparam logic [7:0]  STATUS_TOPD_MASK = 8'h18;

	typedef logic [SHADOW_COUNT-1:0][7:0] cii_ctx_t;

	typedef enum logic [1:0] {ST_RUN, ST_FLUSH, ST_VECTOR} cii_state_t;

endpackage

// ---- cii_edge_if.sv ----
// Purpose: carrier between the unit and its external pin edge detector
// Assumes: all signals sampled on pclk
// Notes:   edge_event is a one-cycle pulse
`timescale 1ns/1ps
interface cii_edge_if;
	logic pin_level;      // external pin level
	logic edge_rising_sel; // 1 rising, 0 falling
	logic edge_event;     // selected edge seen

	modport detector (input pin_level, input edge_rising_sel, output edge_event);
	modport owner    (output pin_level, output edge_rising_sel, input edge_event);
endinterface

// ---- cii_edge_detect.sv ----
// Purpose: edge-triggered event from the external interrupt pin
// Assumes: pin level is synchronous to pclk
// Notes:   one pulse per selected edge, registered
`timescale 1ns/1ps
module cii_edge_detect
	import cii_pkg::*;
(
	input  wire logic pclk,    // clock
	input  wire logic presetn, // async reset, low
	cii_edge_if.detector eif   // pin and event
);
	logic pin_prev;
	logic next_event;

	// rising or falling edge as selected
	assign next_event = eif.edge_rising_sel ? (eif.pin_level & ~pin_prev)
	                                        : (~eif.pin_level & pin_prev);

	// previous level; the reset level of 0 means a high pin at release looks
	// like a rising edge, which is harmless since enables are cleared then
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_prev       <= 1'h0;
			eif.edge_event <= 1'h0;
		end
		else
		begin
			pin_prev       <= eif.pin_level;
			eif.edge_event <= next_event;
		end
	end
endmodule

// ---- cii_chk_properties.sv ----
// Purpose: port-level checks of the core interrupt unit
// Assumes: one pclk domain, presetn async low
// Notes:   looks at outputs and the inputs that cause them
`timescale 1ns/1ps
module cii_chk
	import cii_pkg::*;
(
	input wire logic			pclk,			// clock
	input wire logic			presetn,		// reset, low
	input wire logic			core_sleeping,		// asleep
	input wire logic			irq_ret_exec,		// return
	input wire logic [cii_pkg::PC_W-1:0]	core_pc,		// pc
	input wire cii_pkg::cii_ctx_t		ctx_live,		// live ctx
	input wire logic			phase_first,		// phase one
	input wire logic			flush_prefetch,		// flush
	input wire logic			push_pc,		// push
	input wire logic [cii_pkg::PC_W-1:0]	push_value,		// ret addr
	input wire logic			load_pc,		// load
	input wire logic [cii_pkg::PC_W-1:0]	load_value,		// vector
	input wire logic			pop_pc,			// pop
	input wire logic			ctx_restore_valid,	// restore
	input wire cii_pkg::cii_ctx_t		ctx_restore,		// shadows
	input wire logic			wake_req,		// wake
	input wire logic			irq_request		// request
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// entry: flush first, push and vector load two instruction cycles later
	sequence entry_s;
		flush_prefetch ##8 (push_pc && load_pc);
	endsequence

	entry_order_a: assert property (flush_prefetch |-> entry_s)
		else $error("entry steps out of order");
	flush_cause_a: assert property (flush_prefetch |->
		$past(irq_request, 5) && $past(phase_first) && !$past(core_sleeping))
		else $error("flush without sampled request");
	vector_addr_a: assert property (load_pc |-> load_value == IRQ_VECTOR)
		else $error("wrong vector");
	push_addr_a: assert property (push_pc |-> push_value == $past(core_pc))
		else $error("wrong return address");
	ctx_save_a: assert property (push_pc |-> ctx_restore[SH_W] == $past(ctx_live[SH_W]) &&
		ctx_restore[SH_STATUS] == ($past(ctx_live[SH_STATUS]) & ~STATUS_TOPD_MASK))
		else $error("context not saved");
	return_pulse_a: assert property (irq_ret_exec |=> pop_pc && ctx_restore_valid)
		else $error("return without pop");
	phase_period_a: assert property (phase_first |=> !phase_first [*3] ##1 phase_first)
		else $error("phase one not every fourth clock");
	wake_gate_a: assert property (wake_req |-> core_sleeping)
		else $error("wake while awake");
	no_reentry_a: assert property (push_pc |=> !flush_prefetch [*8])
		else $error("entry during service");
endmodule

bind cii_core_irq cii_chk u_chk (.pclk, .presetn, .core_sleeping, .irq_ret_exec, .core_pc, .ctx_live,
	.phase_first, .flush_prefetch, .push_pc, .push_value, .load_pc, .load_value, .pop_pc,
	.ctx_restore_valid, .ctx_restore, .wake_req, .irq_request);

// ---- cii_core_model.sv ----
// Purpose: behavioural core sequencer beside the interrupt unit
// Assumes: pc steps on each first phase
// Notes:   W counts up so a restore from shadows is visible
`timescale 1ns/1ps
module cii_core_model
	import cii_pkg::*;
(
	input wire logic			pclk,			// clock
	input wire logic			presetn,		// reset, low
	input wire logic			phase_first,		// cycle start
	input wire logic			push_pc,		// push
	input wire logic [cii_pkg::PC_W-1:0]	push_value,		// ret addr
	input wire logic			load_pc,		// load vector
	input wire logic [cii_pkg::PC_W-1:0]	load_value,		// vector
	input wire logic			pop_pc,			// pop
	input wire logic			ctx_restore_valid,	// restore
	input wire cii_pkg::cii_ctx_t		ctx_restore,		// shadows
	output cii_pkg::cii_ctx_t		ctx_live,		// context
	output logic [cii_pkg::PC_W-1:0]	core_pc			// pc
);
	logic [cii_pkg::PC_W-1:0] stack [$];

	// stack and pc follow the unit's pulses; no underflow guard, pushes pair with pops
	always @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			core_pc <= 15'h0100;
			ctx_live <= '0;
			ctx_live[SH_STATUS] <= 8'h18;
		end
		else
		begin
			if (push_pc)
				stack.push_back(push_value);
			if (load_pc)
				core_pc <= load_value;
			else if (pop_pc)
				core_pc <= stack.pop_back();
			else if (phase_first)
				core_pc <= core_pc + 15'h0001;
			// timeout and powerdown bits stay live, shadows hold them as 0
			if (ctx_restore_valid)
			begin
				ctx_live <= ctx_restore;
				ctx_live[SH_STATUS][4:3] <= ctx_live[SH_STATUS][4:3];
			end
			else if (phase_first)
				ctx_live[SH_W] <= ctx_live[SH_W] + 8'h01;
		end
endmodule

// ---- tb_top.sv ----
// Purpose: self-checking bench for the core interrupt unit
// Assumes: zero-wait apb slave, four clocks per instruction
// Notes:   latency counted in clocks to vector execution
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	import cii_pkg::*;
	logic			pclk, presetn, psel, penable, pwrite, pready, pslverr, err, q;
	logic			ext_pin, timer_ovf_event, ioc_pending, core_sleeping, irq_ret_exec;
	logic			phase_first, flush_prefetch, push_pc, load_pc, pop_pc, ctx_restore_valid;
	logic			wake_req, irq_request;
	logic [ADDR_W-1:0]	paddr;
	logic [7:0]		periph_event_a, periph_event_b, periph_event_c;
	logic [DATA_W-1:0]	pwdata, prdata, rd;
	logic [PC_W-1:0]	core_pc, push_value, load_value;
	cii_ctx_t		ctx_live, ctx_restore;
	int			n_fail, compares, cyc, n;

	cii_core_irq u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .ext_pin, .timer_ovf_event, .ioc_pending, .periph_event_a, .periph_event_b,
		.periph_event_c, .core_sleeping, .irq_ret_exec, .core_pc, .ctx_live, .phase_first,
		.flush_prefetch, .push_pc, .push_value, .load_pc, .load_value, .pop_pc, .ctx_restore_valid,
		.ctx_restore, .wake_req, .irq_request);
	cii_core_model u_core (.pclk, .presetn, .phase_first, .push_pc, .push_value, .load_pc, .load_value,
		.pop_pc, .ctx_restore_valid, .ctx_restore, .ctx_live, .core_pc);

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// hang guard, the run needs well under a thousand clocks
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_fail++;
			print_verdict();
		end
	end

	task automatic print_verdict;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// one transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		`CHK(rd, {24'h000000, e});
	endtask

	// bounded wait for an entry, n counts clocks
	task automatic wflush;
		n = 0;
		do
		begin
			@(negedge pclk);
			n++;
		end
		while (flush_prefetch !== 1'b1 && n < 60);
	endtask

	task automatic quiet(input int k);
		q = 1'b0;
		repeat (k)
		begin
			@(negedge pclk);
			q = q | flush_prefetch;
		end
	endtask

	task automatic tmr_pulse;
		@(posedge pclk) timer_ovf_event <= 1'b1;
		@(posedge pclk) timer_ovf_event <= 1'b0;
	endtask

	task automatic ret_pulse;
		@(posedge pclk) irq_ret_exec <= 1'b1;
		@(posedge pclk) irq_ret_exec <= 1'b0;
		@(negedge pclk);
		`CHK({pop_pc, ctx_restore_valid}, 2'b11);
	endtask

	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{ext_pin, timer_ovf_event, ioc_pending, core_sleeping, irq_ret_exec} = '0;
		{periph_event_a, periph_event_b, periph_event_c} = '0;
		presetn = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// reset state, shadow access, unmapped and unimplemented places
		rdchk(ADDR_CTRL, CTRL_RESET);
		apb(1'b0, ADDR_OPTION, 8'h00);
		`CHK(rd[BIT_EDGE_SEL], EDGE_SEL_RESET);
		for (int i = 0; i < SHADOW_COUNT; i++)
			wr(ADDR_SHADOW + 8'(4 * i), 8'(8'ha0 + i));
		for (int i = 0; i < SHADOW_COUNT; i++)
			rdchk(ADDR_SHADOW + 8'(4 * i), 8'(8'ha0 + i));
		apb(1'b0, 8'h40, 8'h00);
		`CHK({err, rd}, 33'h100000000);
		wr(ADDR_PIE_B, 8'hff);
		rdchk(ADDR_PIE_B, PERIPH_IMPL_B);
		wr(ADDR_PIE_B, 8'h00);
		$display("test registers done");
		// flags record events with every enable off
		tmr_pulse();
		rdchk(ADDR_CTRL, 8'h04);
		`CHK(irq_request, 1'b0);
		wr(ADDR_CTRL, 8'h00);
		// peripheral source is held back until the group enable is set
		wr(ADDR_PIE_A, 8'h01);
		wr(ADDR_CTRL, 8'h80);
		@(posedge pclk) periph_event_a <= 8'h01;
		@(posedge pclk) periph_event_a <= 8'h00;
		quiet(12);
		`CHK(q, 1'b0);
		rdchk(ADDR_PIR_A, 8'h01);
		wr(ADDR_CTRL, 8'hc0);
		@(negedge pclk);
		`CHK(irq_request, 1'b1);
		wflush();
		`CHK(flush_prefetch, 1'b1);
		repeat (8) @(negedge pclk);
		`CHK({push_pc, load_pc, load_value}, {2'b11, IRQ_VECTOR});
		@(negedge pclk);
		`CHK(core_pc, IRQ_VECTOR);
		rdchk(ADDR_CTRL, 8'h40);
		$display("test entry done");
		// pin edge during service only raises its flag
		wr(ADDR_CTRL, 8'h50);
		@(posedge pclk) ext_pin <= 1'b1;
		quiet(12);
		`CHK(q, 1'b0);
		rdchk(ADDR_CTRL, 8'h52);
		wr(ADDR_PIR_A, 8'h00);
		wr(ADDR_SHADOW, 8'h5a);
		ret_pulse();
		@(negedge pclk);
		`CHK(ctx_live[SH_W], 8'h5a);
		wflush();
		`CHK(flush_prefetch, 1'b1);
		repeat (4) @(negedge pclk);
		wr(ADDR_CTRL, 8'h00);
		ret_pulse();
		wr(ADDR_CTRL, 8'h00);
		$display("test service done");
		// falling pin edge, then a timer pulse, measured to the vector
		wr(ADDR_OPTION, 8'h00);
		wr(ADDR_CTRL, 8'h90);
		@(posedge pclk) ext_pin <= 1'b0;
		wflush();
		`CHK((n + 7) inside {[12:20]}, 1'b1);
		repeat (8) @(negedge pclk);
		rdchk(ADDR_CTRL, 8'h12);
		wr(ADDR_CTRL, 8'h00);
		ret_pulse();
		wr(ADDR_CTRL, 8'ha0);
		tmr_pulse();
		wflush();
		`CHK((n + 7) inside {[12:16]}, 1'b1);
		repeat (4) @(negedge pclk);
		wr(ADDR_CTRL, 8'h00);
		ret_pulse();
		wr(ADDR_CTRL, 8'h00);
		$display("test latency done");
		// timer cannot wake; pin wakes, vector waits one instruction
		core_sleeping <= 1'b1;
		wr(ADDR_CTRL, 8'h20);
		tmr_pulse();
		@(negedge pclk);
		`CHK(wake_req, 1'b0);
		wr(ADDR_OPTION, 8'h40);
		wr(ADDR_CTRL, 8'h90);
		@(posedge pclk) ext_pin <= 1'b1;
		quiet(8);
		`CHK({q, wake_req}, 2'b01);
		@(posedge pclk) core_sleeping <= 1'b0;
		quiet(4);
		`CHK(q, 1'b0);
		wflush();
		`CHK(flush_prefetch, 1'b1);
		repeat (8) @(negedge pclk);
		$display("test sleep done");
		print_verdict();
	end
endmodule
